// ==== core/pcp_pkg.sv ====
package pcp_pkg;
	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [11:0] IDX_PTT = 12'h100;
	localparam logic [11:0] IDX_PFILT = 12'h108;
	localparam logic [11:0] IDX_GNUM2 = 12'h10F;
	localparam logic [11:0] IDX_GNUM1 = 12'h12C;
	localparam logic [11:0] IDX_GDEN = 12'h12D;
	localparam logic [11:0] IDX_KPP = 12'h200;
	localparam logic [11:0] IDX_PPR = 12'h201;
	localparam logic [11:0] IDX_PFG = 12'h202;
	localparam logic [11:0] IDX_PFF = 12'h203;
	localparam logic [11:0] IDX_CTRL = 12'h300;
	localparam logic [11:0] IDX_ATRESP = 12'h301;
	localparam logic [11:0] IDX_PERR = 12'h302;
	localparam logic [11:0] IDX_SPD = 12'h303;
	localparam int ADDR_W = 14;
	// ------------------------------------------------------------
	// reset values and legal ranges
	// ------------------------------------------------------------
	localparam logic [1:0] RST_PTT = 2'h2;
	localparam logic [15:0] RST_PFILT = 16'h0000;
	localparam logic [15:0] RST_GEAR = 16'h0001;
	localparam logic [15:0] RST_KPP = 16'h0032;
	localparam logic [15:0] RST_PPR = 16'h0064;
	localparam logic [15:0] RST_PFG = 16'h0000;
	localparam logic [15:0] RST_PFF = 16'h0005;
	localparam logic [15:0] RST_CTRL = 16'h0001;
	localparam logic [15:0] RST_ATRESP = 16'h0005;
	localparam logic [15:0] GEAR_MIN = 16'h0001;
	localparam logic [15:0] GEAR_MAX = 16'h7FFF;
	localparam logic [15:0] PFILT_MAX = 16'h03E8;
	localparam logic [15:0] KPP_MAX = 16'h03FF;
	localparam logic [15:0] PPR_MIN = 16'h000A;
	localparam logic [15:0] PPR_MAX = 16'h01F4;
	localparam logic [15:0] PFG_MAX = 16'h0064;
	localparam logic [15:0] PFF_MIN = 16'h0002;
	localparam logic [15:0] PFF_MAX = 16'h0064;
	localparam logic [15:0] PTT_MAX = 16'h0002;
	localparam logic [15:0] ATRESP_MIN = 16'h0001;
	localparam logic [15:0] ATRESP_MAX = 16'h0064;
	localparam logic [15:0] PCT = 16'h0064;
	localparam logic [15:0] AT_KP_MUL = 16'h0006;
	localparam logic [15:0] AT_PFG = 16'h0032;
	// control register bits
	localparam int CTRL_POS_MODE = 0;
	localparam int CTRL_AUTO = 1;
	localparam int CTRL_GSEL_EN = 2;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 25;
	localparam int CYCLE_NS = 62500;
	localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;
	localparam int PFILT_UNIT_NS = 10000000;
	localparam int PFF_UNIT_NS = 1000000;
	localparam int PFILT_CYC = PFILT_UNIT_NS / CYCLE_NS;
	localparam int PFF_CYC = PFF_UNIT_NS / CYCLE_NS;
	localparam int CPS = 1000000000 / CYCLE_NS;
	localparam int DIV_CLKS = 300;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PT_AB = 2'h0, PT_CWCCW = 2'h1, PT_PDIR = 2'h2} pcp_ptype_t;
	typedef enum logic [1:0] {S_IDLE = 2'h0, S_PREP = 2'h1, S_DIV = 2'h2, S_POST = 2'h3} pcp_st_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} pcp_apb_req_t;
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic signed [1:0] step;
	} pcp_dec_t;
	typedef struct packed {
		logic [1:0] pulse_type_setting;
		logic [15:0] pfilt;
		logic [15:0] g2;
		logic [15:0] g1;
		logic [15:0] gden;
		logic [15:0] position_loop_gain;
		logic [15:0] ppr;
		logic [15:0] position_feedforward_gain;
		logic [15:0] feedforward_smooth_constant;
		logic [15:0] ctrl;
		logic [15:0] resp;
	} pcp_cfg_t;
	typedef struct packed {
		pcp_cfg_t cfg;
		logic [1:0] bsync;
		logic [1:0] gsync;
		logic [15:0] tick_cnt;
		logic signed [15:0] cmd_acc;
		logic signed [23:0] fb_acc;
		logic signed [15:0] cnt_s;
		logic signed [23:0] fb_s;
		logic [15:0] gnum;
		logic signed [31:0] grem;
		logic signed [31:0] pos_cmd;
		logic signed [31:0] pos_filt;
		logic signed [31:0] d_filt;
		logic signed [31:0] err;
		logic signed [31:0] ffs;
		logic signed [31:0] spd;
		logic [15:0] kp_used;
		pcp_st_t st;
		logic [1:0] ph;
		logic [5:0] bit_i;
		logic neg;
		logic [63:0] dn;
		logic [63:0] q;
		logic [23:0] dv;
		logic [24:0] r;
		logic spd_vld;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pcp_state_t;
endpackage : pcp_pkg

// ==== core/pcp_pulse_dec.sv ====
`timescale 1ns/100ps
module pcp_pulse_dec (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pin_a,
	input wire logic pin_b,
	input wire pcp_pkg::pcp_ptype_t ptype,
	output logic signed [1:0] step
);
	import pcp_pkg::*;
	pcp_dec_t s;
	pcp_dec_t n;
	logic a;
	logic b;
	logic pa;
	logic pb;
	logic up;
	logic dn;
	// ------------------------------------------------------------
	// decode: one count step per clock at most
	// ------------------------------------------------------------
	always_comb begin
		n = s;
		n.s1 = {pin_b, pin_a};
		n.s2 = s.s1;
		n.s3 = s.s2;
		a = s.s2[0];
		b = s.s2[1];
		pa = s.s3[0];
		pb = s.s3[1];
		up = 1'b0;
		dn = 1'b0;
		case (ptype)
			PT_AB: begin
				// both phases moving at once is a lost edge, counted as nothing
				up = a ^ pb;
				dn = pa ^ b;
			end
			PT_CWCCW: begin
				up = a & ~pa;
				dn = b & ~pb;
			end
			PT_PDIR: begin
				up = a & ~pa & ~b;
				dn = a & ~pa & b;
			end
			default: begin
				up = 1'b0;
				dn = 1'b0;
			end
		endcase
		n.step = (up & ~dn) ? 2'sb01 : ((dn & ~up) ? 2'sb11 : 2'sb00);
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
	assign step = s.step;
endmodule : pcp_pulse_dec

// ==== core/pcp_core.sv ====
// Functional notes
// - while pulse blocking is active in position mode, command pulses are dropped.
// - gear numerator is the second setting when gear select is enabled and high, else the first.
// - gear numerators and denominator accept 1..32767 only and reset to 1.
// - command count is scaled by numerator over denominator with exact remainder carry.
// - position command passes a first-order low-pass in 10 ms units, 0 bypasses it.
// - proportional position gain 0..1023, reset 50, turns error into speed command.
// - in auto tuning, position gain is six times the responsiveness setting and feed-forward gain is fixed at 50.
// - when gain switching is active the position gain is scaled by a 10..500 percent rate.
// - a feed-forward term weighted 0..100 percent, reset 0, adds to the loop output.
// - the feed-forward term is smoothed with a 2..100 ms constant, reset 5.
// - pulses decode as quadrature 4x, separate cw/ccw, or pulse plus direction.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module pcp_core #(
	parameter int CYCLE_CLKS = pcp_pkg::CYCLE_CLKS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire pcp_pkg::pcp_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pulse_a,
	input wire logic pulse_b,
	input wire logic pulse_block_function,
	input wire logic gear_select_input,
	input wire logic gain_switch_cond,
	input wire logic signed [7:0] fb_inc,
	output logic signed [31:0] speed_cmd,
	output logic speed_cmd_valid
);
	import pcp_pkg::*;
	if (CYCLE_CLKS < DIV_CLKS || CYCLE_CLKS > 65535) begin : g_chk
		$error("CYCLE_CLKS must leave room for the divider and fit 16 bits");
	end
	pcp_state_t s;
	pcp_state_t n;
	logic signed [1:0] dec_step;
	logic inh;
	logic tick;
	logic auto_on;
	logic signed [15:0] step;
	logic [15:0] kp_base;
	logic [15:0] pfg_e;
	logic [15:0] rate;
	logic signed [63:0] num;
	logic [23:0] den;
	logic [24:0] rsh;
	logic signed [63:0] qs;
	logic signed [31:0] rm;
	logic signed [31:0] dfl;
	logic filt_done;
	logic setup;
	logic acc;
	logic [11:0] idx;
	logic hit;
	logic [31:0] rd;
	logic [15:0] wv;

	function automatic logic fits(input logic [31:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		fits = (v[31:16] == 16'h0000) && (v[15:0] >= lo) && (v[15:0] <= hi);
	endfunction : fits

	pcp_pulse_dec u_dec (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_a(pulse_a),
		.pin_b(pulse_b),
		.ptype(pcp_ptype_t'(s.cfg.pulse_type_setting)),
		.step(dec_step)
	);

	always_comb begin
		n = s;
		n.spd_vld = 1'b0;
		num = '0;
		den = 24'h000001;
		rsh = '0;
		qs = '0;
		rm = '0;
		dfl = '0;
		filt_done = 1'b0;
		// ------------------------------------------------------------
		// pins and per-clock accumulation
		// ------------------------------------------------------------
		n.bsync = {s.bsync[0], pulse_block_function};
		n.gsync = {s.gsync[0], gear_select_input};
		inh = s.bsync[1] & s.cfg.ctrl[CTRL_POS_MODE];
		step = inh ? 16'sh0000 : 16'(dec_step);
		tick = (s.tick_cnt == 16'(CYCLE_CLKS - 1));
		n.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;
		n.cmd_acc = tick ? step : s.cmd_acc + step;
		n.fb_acc = tick ? 24'(fb_inc) : s.fb_acc + 24'(fb_inc);
		auto_on = s.cfg.ctrl[CTRL_AUTO];
		kp_base = auto_on ? 16'(s.cfg.resp * AT_KP_MUL) : s.cfg.position_loop_gain;
		pfg_e = auto_on ? AT_PFG : s.cfg.position_feedforward_gain;
		rate = gain_switch_cond ? s.cfg.ppr : PCT;
		// ------------------------------------------------------------
		// control cycle sequence, one shared divider
		// ------------------------------------------------------------
		case (s.st)
			S_IDLE: begin
				if (tick) begin
					n.cnt_s = s.cmd_acc;
					n.fb_s = s.fb_acc;
					// numerator latched per cycle so a select edge never splits a step
					n.gnum = (s.cfg.ctrl[CTRL_GSEL_EN] & s.gsync[1]) ? s.cfg.g2 : s.cfg.g1;
					n.ph = 2'h0;
					n.st = S_PREP;
				end
			end
			S_PREP: begin
				n.st = S_DIV;
				n.bit_i = 6'h3F;
				n.q = '0;
				n.r = '0;
				case (s.ph)
					2'h0: begin
						num = 64'(s.cnt_s) * 64'(signed'({1'b0, s.gnum})) + 64'(s.grem);
						den = 24'(s.cfg.gden);
					end
					2'h1: begin
						if (s.cfg.pfilt == 16'h0000) begin
							dfl = s.pos_cmd - s.pos_filt;
							filt_done = 1'b1;
							n.ph = 2'h2;
							n.st = S_PREP;
						end
						num = 64'(s.pos_cmd) - 64'(s.pos_filt);
						// widened before the product: 1000 x 160 does not fit 16 bits
						den = 24'(s.cfg.pfilt) * 24'(PFILT_CYC);
					end
					2'h2: begin
						// feed-forward kept scaled by 100 to avoid a second division
						num = 64'(s.d_filt) * 64'(signed'({1'b0, pfg_e})) * 64'(CPS)
							- 64'(s.ffs);
						den = 24'(s.cfg.feedforward_smooth_constant * 16'(PFF_CYC));
					end
					default: begin
						num = 64'(s.err) * 64'(signed'({1'b0, kp_base}))
							* 64'(signed'({1'b0, rate})) + 64'(s.ffs);
						den = 24'(PCT);
						n.kp_used = kp_base;
					end
				endcase
				n.neg = num[63];
				n.dn = num[63] ? 64'(-num) : 64'(num);
				n.dv = den;
			end
			S_DIV: begin
				rsh = {s.r[23:0], s.dn[s.bit_i]};
				if (rsh >= {1'b0, s.dv}) begin
					n.r = rsh - {1'b0, s.dv};
					n.q[s.bit_i] = 1'b1;
				end else begin
					n.r = rsh;
				end
				if (s.bit_i == 6'h00) begin
					n.st = S_POST;
				end else begin
					n.bit_i = s.bit_i - 6'h01;
				end
			end
			S_POST: begin
				qs = s.neg ? -signed'(s.q) : signed'(s.q);
				rm = s.neg ? -32'(signed'({1'b0, s.r})) : 32'(signed'({1'b0, s.r}));
				n.st = S_PREP;
				n.ph = s.ph + 2'h1;
				case (s.ph)
					2'h0: begin
						n.grem = rm;
						n.pos_cmd = s.pos_cmd + 32'(qs);
					end
					2'h1: begin
						dfl = 32'(qs);
						filt_done = 1'b1;
					end
					2'h2: begin
						n.ffs = s.ffs + 32'(qs);
					end
					default: begin
						n.spd = 32'(qs);
						n.spd_vld = 1'b1;
						n.st = S_IDLE;
					end
				endcase
			end
			default: begin
				n.st = S_IDLE;
			end
		endcase
		if (filt_done) begin
			n.d_filt = dfl;
			n.pos_filt = s.pos_filt + dfl;
			n.err = s.err + dfl - 32'(s.fb_s);
		end
		// ------------------------------------------------------------
		// apb slave: no wait state, every output is a flop set from the setup cycle
		// ------------------------------------------------------------
		setup = apb_req.psel & ~apb_req.penable;
		acc = apb_req.psel & apb_req.penable & s.pready;
		idx = apb_req.paddr[ADDR_W-1:2];
		wv = apb_req.pwdata[15:0];
		hit = 1'b1;
		case (idx)
			IDX_PTT: rd = {30'h0, s.cfg.pulse_type_setting};
			IDX_PFILT: rd = {16'h0, s.cfg.pfilt};
			IDX_GNUM2: rd = {16'h0, s.cfg.g2};
			IDX_GNUM1: rd = {16'h0, s.cfg.g1};
			IDX_GDEN: rd = {16'h0, s.cfg.gden};
			IDX_KPP: rd = {16'h0, s.cfg.position_loop_gain};
			IDX_PPR: rd = {16'h0, s.cfg.ppr};
			IDX_PFG: rd = {16'h0, s.cfg.position_feedforward_gain};
			IDX_PFF: rd = {16'h0, s.cfg.feedforward_smooth_constant};
			IDX_CTRL: rd = {16'h0, s.cfg.ctrl};
			IDX_ATRESP: rd = {16'h0, s.cfg.resp};
			IDX_PERR: rd = s.err;
			IDX_SPD: rd = s.spd;
			default: begin
				rd = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
		n.pready = setup;
		n.pslverr = setup & ~hit;
		if (setup) begin
			n.prdata = rd;
		end
		// out-of-range values are dropped and the old setting stays, except ctrl, which keeps bits 2:0 of any write
		if (acc & apb_req.pwrite) begin
			case (idx)
				IDX_PTT: if (fits(apb_req.pwdata, 16'h0000, PTT_MAX)) n.cfg.pulse_type_setting = wv[1:0];
				IDX_PFILT: if (fits(apb_req.pwdata, 16'h0000, PFILT_MAX)) n.cfg.pfilt = wv;
				IDX_GNUM2: if (fits(apb_req.pwdata, GEAR_MIN, GEAR_MAX)) n.cfg.g2 = wv;
				IDX_GNUM1: if (fits(apb_req.pwdata, GEAR_MIN, GEAR_MAX)) n.cfg.g1 = wv;
				IDX_GDEN: if (fits(apb_req.pwdata, GEAR_MIN, GEAR_MAX)) n.cfg.gden = wv;
				IDX_KPP: if (fits(apb_req.pwdata, 16'h0000, KPP_MAX)) n.cfg.position_loop_gain = wv;
				IDX_PPR: if (fits(apb_req.pwdata, PPR_MIN, PPR_MAX)) n.cfg.ppr = wv;
				IDX_PFG: if (fits(apb_req.pwdata, 16'h0000, PFG_MAX)) n.cfg.position_feedforward_gain = wv;
				IDX_PFF: if (fits(apb_req.pwdata, PFF_MIN, PFF_MAX)) n.cfg.feedforward_smooth_constant = wv;
				IDX_CTRL: n.cfg.ctrl = {13'h0, wv[2:0]};
				IDX_ATRESP: if (fits(apb_req.pwdata, ATRESP_MIN, ATRESP_MAX)) n.cfg.resp = wv;
				default: n.cfg = s.cfg;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
			s.cfg.pulse_type_setting <= RST_PTT;
			s.cfg.pfilt <= RST_PFILT;
			s.cfg.g2 <= RST_GEAR;
			s.cfg.g1 <= RST_GEAR;
			s.cfg.gden <= RST_GEAR;
			s.cfg.position_loop_gain <= RST_KPP;
			s.cfg.ppr <= RST_PPR;
			s.cfg.position_feedforward_gain <= RST_PFG;
			s.cfg.feedforward_smooth_constant <= RST_PFF;
			s.cfg.ctrl <= RST_CTRL;
			s.cfg.resp <= RST_ATRESP;
			s.st <= S_IDLE;
			s.dv <= 24'h000001;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign speed_cmd = s.spd;
	assign speed_cmd_valid = s.spd_vld;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_block_holds;
		@(posedge sys_clk) disable iff (rst)
		(s.bsync[1] && s.cfg.ctrl[CTRL_POS_MODE] && !tick) |=> (s.cmd_acc == $past(s.cmd_acc));
	endproperty
	a_block_holds: assert property (p_block_holds) else $error("blocked pulse counted");
	property p_gear_sel;
		@(posedge sys_clk) disable iff (rst)
		(s.st == S_IDLE && tick && s.cfg.ctrl[CTRL_GSEL_EN] && s.gsync[1])
			|=> (s.gnum == $past(s.cfg.g2)) && (s.st == S_PREP);
	endproperty
	a_gear_sel: assert property (p_gear_sel) else $error("second numerator not taken");
	property p_gear_range;
		@(posedge sys_clk) disable iff (rst)
		(s.cfg.g1 >= GEAR_MIN) && (s.cfg.g2 >= GEAR_MIN) && (s.cfg.gden >= GEAR_MIN)
			&& (s.cfg.g1 <= GEAR_MAX) && (s.cfg.g2 <= GEAR_MAX) && (s.cfg.gden <= GEAR_MAX);
	endproperty
	a_gear_range: assert property (p_gear_range) else $error("gear setting out of range");
	property p_gear_rem;
		@(posedge sys_clk) disable iff (rst)
		(s.st == S_POST && s.ph == 2'h0) |=>
			((s.grem < 0 ? -s.grem : s.grem) < 32'(signed'({1'b0, s.cfg.gden})));
	endproperty
	a_gear_rem: assert property (p_gear_rem) else $error("gear remainder too large");
	property p_filt_bypass;
		@(posedge sys_clk) disable iff (rst)
		(s.st == S_PREP && s.ph == 2'h1 && s.cfg.pfilt == 16'h0000)
			|=> (s.pos_filt == s.pos_cmd) && (s.ph == 2'h2);
	endproperty
	a_filt_bypass: assert property (p_filt_bypass) else $error("filter not bypassed");
	property p_kpp_range;
		@(posedge sys_clk) disable iff (rst)
		(s.cfg.position_loop_gain <= KPP_MAX) && (s.cfg.position_feedforward_gain <= PFG_MAX);
	endproperty
	a_kpp_range: assert property (p_kpp_range) else $error("gain out of range");
	property p_auto_gain;
		@(posedge sys_clk) disable iff (rst)
		(s.st == S_PREP && s.ph == 2'h3 && s.cfg.ctrl[CTRL_AUTO])
			|=> (s.kp_used == 16'($past(s.cfg.resp) * AT_KP_MUL));
	endproperty
	a_auto_gain: assert property (p_auto_gain) else $error("auto gain not applied");
	property p_rate_range;
		@(posedge sys_clk) disable iff (rst)
		(s.cfg.ppr >= PPR_MIN) && (s.cfg.ppr <= PPR_MAX)
			&& (s.cfg.feedforward_smooth_constant >= PFF_MIN) && (s.cfg.feedforward_smooth_constant <= PFF_MAX);
	endproperty
	a_rate_range: assert property (p_rate_range) else $error("rate or smoothing out of range");
	property p_cycle_done;
		@(posedge sys_clk) disable iff (rst)
		(tick && s.st == S_IDLE) |-> ##[200:265] s.spd_vld;
	endproperty
	a_cycle_done: assert property (p_cycle_done) else $error("control cycle not finished");
	c_block: cover property (@(posedge sys_clk) disable iff (rst) inh && dec_step != 2'sb00);
	c_gear2: cover property (@(posedge sys_clk) disable iff (rst) s.gnum == s.cfg.g2 && s.gnum != s.cfg.g1);
	c_filter: cover property (@(posedge sys_clk) disable iff (rst) s.st == S_DIV && s.ph == 2'h1);
	c_auto: cover property (@(posedge sys_clk) disable iff (rst) s.spd_vld && s.cfg.ctrl[CTRL_AUTO]);
endmodule : pcp_core

// ==== sim/pcp_pulse_src.sv ====
`timescale 1ns/100ps
module pcp_pulse_src (
	input wire logic sys_clk,
	input wire pcp_pkg::pcp_ptype_t ptype,
	output logic pin_a,
	output logic pin_b
);
	import pcp_pkg::*;
	// ------------------------------------------------------------
	// controller pulse train
	// ------------------------------------------------------------
	// forward order puts phase a ahead of phase b
	logic [1:0] gray [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
	logic [1:0] ph = 2'h0;
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b0;
	end
	// every level stands 4 clocks, four times the narrowest pulse the decoder accepts
	task automatic hold();
		repeat (4) @(posedge sys_clk);
	endtask : hold
	// for the quadrature type one unit is a full a/b period
	task automatic send(input int n, input bit rev);
		for (int i = 0; i < n; i++) begin
			if (ptype == PT_AB) begin
				for (int k = 0; k < 4; k++) begin
					ph = rev ? ph - 2'h1 : ph + 2'h1;
					{pin_a, pin_b} <= gray[ph];
					hold();
				end
			end else if (ptype == PT_CWCCW) begin
				pin_a <= !rev;
				pin_b <= rev;
				hold();
				pin_a <= 1'b0;
				pin_b <= 1'b0;
				hold();
			end else begin
				pin_b <= rev;
				hold();
				pin_a <= 1'b1;
				hold();
				pin_a <= 1'b0;
				hold();
			end
		end
	endtask : send
endmodule : pcp_pulse_src

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	import pcp_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	pcp_apb_req_t apb_req = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pin_a;
	logic pin_b;
	logic pulse_block_function = 1'b0;
	logic gear_select_input = 1'b0;
	logic gain_switch_cond = 1'b0;
	logic signed [7:0] fb_inc = 8'sh00;
	logic signed [31:0] speed_cmd;
	logic speed_cmd_valid;
	pcp_ptype_t ptype = PT_PDIR;
	int fail_count = 0;
	int total_checks = 0;
	longint exp_err = 0;
	longint kp = 1;
	longint rate = 100;
	logic [31:0] rd;
	logic er;
	logic [11:0] r_idx [9] = '{IDX_PTT, IDX_PFILT, IDX_GNUM2, IDX_GNUM1, IDX_GDEN, IDX_KPP,
		IDX_PPR, IDX_PFG, IDX_PFF};
	logic [31:0] r_rst [9] = '{32'h2, 32'h0, 32'h1, 32'h1, 32'h1, 32'h32, 32'h64, 32'h0, 32'h5};
	logic [31:0] r_bad [9] = '{32'h3, 32'h3E9, 32'h0, 32'h8000, 32'h10001, 32'h400, 32'h9,
		32'h65, 32'h1};
	logic [31:0] r_ok [9] = '{32'h0, 32'h3E8, 32'h7FFF, 32'h7FFF, 32'h7FFF, 32'h3FF, 32'h1F4,
		32'h64, 32'h64};
	// short control cycle keeps the run brief; filter math counts in cycles anyway
	pcp_core #(.CYCLE_CLKS(300)) pcp_core_inst (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_a(pin_a), .pulse_b(pin_b),
		.pulse_block_function(pulse_block_function), .gear_select_input(gear_select_input),
		.gain_switch_cond(gain_switch_cond), .fb_inc(fb_inc), .speed_cmd(speed_cmd),
		.speed_cmd_valid(speed_cmd_valid));
	pcp_pulse_src pcp_pulse_src_inst (.sys_clk(sys_clk), .ptype(ptype), .pin_a(pin_a),
		.pin_b(pin_b));
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ------------------------------------------------------------
	// bus and check tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic apb(input bit w, input logic [11:0] idx, input logic [31:0] wd,
		output logic [31:0] d, output logic e);
		int n;
		n = 0;
		@(posedge sys_clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'h0}, pwdata: wd};
		@(posedge sys_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fail_count++;
		end
		d = prdata;
		e = pslverr;
		apb_req <= '0;
	endtask : apb
	task automatic wr(input logic [11:0] idx, input logic [31:0] v);
		logic [31:0] d;
		logic e;
		apb(1'b1, idx, v, d, e);
	endtask : wr
	task automatic rchk(input string name, input logic [11:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		apb(1'b0, idx, 32'h0, d, e);
		chk(name, exp, d);
	endtask : rchk
	// settle lets synced inputs and the per-cycle numerator latch catch up first
	task automatic go(input int n, input bit rev, input longint d);
		int t;
		repeat (400) @(posedge sys_clk);
		pcp_pulse_src_inst.send(n, rev);
		repeat (900) @(posedge sys_clk);
		exp_err += d;
		rchk("position_error", IDX_PERR, 32'(exp_err));
		t = 0;
		while (speed_cmd_valid !== 1'b1 && t < 400) begin
			@(posedge sys_clk);
			t++;
		end
		chk("speed_cmd", 32'(exp_err * kp * rate / 100), speed_cmd);
	endtask : go
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			rchk("reset_value", r_idx[i], r_rst[i]);
			wr(r_idx[i], r_bad[i]);
			rchk("refused_value", r_idx[i], r_rst[i]);
			wr(r_idx[i], r_ok[i]);
			rchk("accepted_value", r_idx[i], r_ok[i]);
			wr(r_idx[i], r_rst[i]);
		end
		apb(1'b1, 12'hFFF, 32'h1, rd, er);
		chk("unmapped_write_error", 32'h1, {31'h0, er});
		apb(1'b0, 12'hFFF, 32'h0, rd, er);
		chk("unmapped_read_error", 32'h1, {31'h0, er});
		chk("unmapped_read_data", 32'h0, rd);
		wr(IDX_PERR, 32'h1234);
		// unit gain makes the speed command equal the error
		wr(IDX_KPP, 32'h1);
		wr(IDX_PPR, 32'hC8);
		wr(IDX_GNUM2, 32'h3);
		go(10, 1'b0, 10);
		go(4, 1'b1, -4);
		pulse_block_function <= 1'b1;
		go(5, 1'b0, 0);
		wr(IDX_CTRL, 32'h0);
		go(3, 1'b0, 3);
		pulse_block_function <= 1'b0;
		wr(IDX_CTRL, 32'h1);
		// gear changes only while no pulses are in flight
		wr(IDX_GDEN, 32'h2);
		go(10, 1'b0, 5);
		gear_select_input <= 1'b1;
		go(4, 1'b0, 2);
		wr(IDX_CTRL, 32'h5);
		go(4, 1'b0, 6);
		gear_select_input <= 1'b0;
		wr(IDX_CTRL, 32'h1);
		wr(IDX_GDEN, 32'h1);
		fb_inc <= 8'sh02;
		repeat (3) @(posedge sys_clk);
		fb_inc <= 8'sh00;
		go(0, 1'b0, -6);
		wr(IDX_PFILT, 32'h1);
		go(8, 1'b0, 0);
		wr(IDX_PFILT, 32'h0);
		go(0, 1'b0, 8);
		gain_switch_cond <= 1'b1;
		rate = 200;
		go(0, 1'b0, 0);
		gain_switch_cond <= 1'b0;
		rate = 100;
		wr(IDX_PTT, 32'h1);
		ptype <= PT_CWCCW;
		go(3, 1'b0, 3);
		go(2, 1'b1, -2);
		wr(IDX_PTT, 32'h0);
		ptype <= PT_AB;
		repeat (400) @(posedge sys_clk);
		pcp_pulse_src_inst.send(1, 1'b0);
		repeat (900) @(posedge sys_clk);
		apb(1'b0, IDX_PERR, 32'h0, rd, er);
		exp_err += 4;
		chk("quadrature_count", 32'(exp_err), rd);
		wr(IDX_CTRL, 32'h3);
		kp = 30;
		go(0, 1'b0, 0);
		complete_run();
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		fail_count++;
		complete_run();
	end
endmodule : tb_top
